/* File: hw/dcc_pkg.sv */
// dcc_pkg: constants, types and register map for the dual comparator control block.
// assumes a 32-bit AXI4-Lite register bus and the block running on aclk.
package dcc_pkg;
	// register byte offsets
	localparam logic [7:0] DCC_CTRL_OFF = 8'h00;
	localparam logic [7:0] DCC_FLAG_OFF = 8'h04;
	localparam logic [7:0] DCC_CFG_OFF = 8'h08;
	localparam logic [7:0] DCC_PORT_OFF = 8'h0C;
	localparam logic [7:0] DCC_TBL_OFF = 8'h10;
	// comparator_control fields
	localparam int DCC_SECOND_RESULT_BIT = 7;
	localparam int DCC_FIRST_RESULT_BIT = 6;
	localparam int DCC_SECOND_INVERT_BIT = 5;
	localparam int DCC_FIRST_INVERT_BIT = 4;
	localparam int DCC_INPUT_SWITCH_BIT = 3;
	localparam int DCC_MODE_LSB = 0;
	localparam logic [7:0] DCC_CTRL_RESET = 8'h00;
	localparam logic [7:0] DCC_CTRL_WMASK = 8'h3F;
	// flag / enable register fields
	localparam int DCC_FLAG_BIT = 0;
	localparam int DCC_ENABLE_BIT = 1;
	localparam int DCC_PERIPH_EN_BIT = 2;
	localparam int DCC_GLOBAL_EN_BIT = 3;
	localparam int DCC_SLEEP_BIT = 4;
	localparam logic [7:0] DCC_FLAG_RESET = 8'h00;
	localparam logic [7:0] DCC_FLAG_WMASK = 8'h1F;
	// direction: 1 = input, reset all inputs
	localparam logic [7:0] DCC_DIR_RESET = 8'hFF;
	localparam int DCC_PIN_FIRST_OUT = 1;
	localparam int DCC_PIN_SECOND_OUT = 2;
	localparam logic [2:0] DCC_MODE_INTREF = 3'h6;
	localparam logic [2:0] DCC_MODE_OFF = 3'h7;
	localparam logic [1:0] DCC_RESP_OKAY = 2'h0;
	localparam logic [1:0] DCC_RESP_SLVERR = 2'h2;
	// decode table entry for modes 001..101, one byte each
	localparam int DCC_TBL_ENTRIES = 8;
	typedef struct packed {
		logic first_on;
		logic second_on;
		logic [1:0] first_neg_sel;
		logic [1:0] second_neg_sel;
		logic first_pin_out;
		logic second_pin_out;
	} dcc_mode_type;
	localparam logic [7:0] DCC_TBL_RESET = 8'hF0;
	typedef struct packed {
		logic second;
		logic first;
	} dcc_pair_type;
endpackage

/* File: hw/dcc_table_mem.sv */
// dcc_table_mem: small register memory holding the mode decode table.
// assumes one writer and one registered read port on aclk.
`timescale 1ns/1ps
`default_nettype none
module dcc_table_mem #(
	parameter int DEPTH = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic wr_en,
	input wire logic [2:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic [2:0] rd_addr,
	output logic [7:0] rd_data
);
	import dcc_pkg::*;
	logic [7:0] mem_r [DEPTH];
	logic [7:0] mem_nxt [DEPTH];
	logic [7:0] rd_data_r;
	logic [7:0] rd_data_nxt;
	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			mem_nxt[i] = (wr_en && wr_addr == 3'(i)) ? wr_data : mem_r[i];
		end
		rd_data_nxt = mem_r[rd_addr];
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_r[i] <= DCC_TBL_RESET;
			end
			rd_data_r <= DCC_TBL_RESET;
		end else begin
			mem_r <= mem_nxt;
			rd_data_r <= rd_data_nxt;
		end
	end
	assign rd_data = rd_data_r;
endmodule // dcc_table_mem
`default_nettype wire

/* File: hw/dcc_top.sv */
// dcc_top: digital control and status for two analog comparators.
// assumes analog results arrive asynchronous; software via AXI4-Lite on aclk.
// Function
// - result high when positive exceeds negative
// - invert bits flip each comparator result
// - results readable at bits 7,6, read-only
// - three-bit mode field selects eight configurations
// - mode 110 routes reference to positive inputs
// - mode 111 powers both comparators off
// - reset clears control, comparators powered down
// - flag set on mismatch with latched outputs
// - mismatch persists; control access relatches outputs
// - software writes flag zero clears, one sets
// - request needs all three enables set
// - comparators run and wake from sleep
// - wake-up leaves control register unchanged
// - pin outputs carry unsynchronized results
// - direction bits gate pin output drivers
// - analog-configured pins read as zero
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module dcc_top #(
	parameter int TBL_DEPTH = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire dcc_pkg::dcc_pair_type raw_result,
	input wire logic [7:0] port_f_pins,
	output dcc_pkg::dcc_pair_type power_on,
	output logic use_internal_ref,
	output logic [1:0] first_neg_sel,
	output logic [1:0] second_neg_sel,
	output logic [7:0] port_f_direction,
	output logic [1:0] pin_out_en,
	output logic [1:0] pin_out_sel,
	output logic irq_req,
	output logic wake_req
);
	import dcc_pkg::*;
	typedef enum logic [2:0] {
		DCC_IDLE = 3'b001,
		DCC_RESP = 3'b010,
		DCC_WAIT = 3'b100
	} dcc_bus_type;

	logic [7:0] ctrl_r, ctrl_nxt, flag_r, flag_nxt, dir_r, dir_nxt, analog_r, analog_nxt;
	dcc_pair_type sync1_r, sync2_r, latch_r, latch_nxt;
	dcc_pair_type res_now;
	dcc_bus_type wst_r, wst_nxt, rst_r, rst_nxt;
	logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
	logic [7:0] awa_r, awa_nxt, tbl_off;
	logic [31:0] wd_r, wd_nxt, rdata_r, rdata_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic do_write, ctrl_touch, tbl_wr;
	logic [7:0] tbl_rd;
	dcc_mode_type cur;
	dcc_pair_type pw_r, pw_nxt, pe_r, pe_nxt;
	logic iref_r, iref_nxt, irq_r, irq_nxt, wake_r, wake_nxt;
	logic [1:0] n1_r, n1_nxt, n2_r, n2_nxt;
	logic [2:0] mode;

	assign mode = ctrl_r[DCC_MODE_LSB +: 3];
	// entry index counted from the table base, so the first word holds mode 0
	assign tbl_off = awa_r - DCC_TBL_OFF;
	// table read port tracks the mode; one cycle of latency after a mode write
	dcc_table_mem #(.DEPTH(TBL_DEPTH)) u_tbl (
		.aclk(aclk),
		.aresetn(aresetn),
		.wr_en(tbl_wr),
		.wr_addr(tbl_off[4:2]),
		.wr_data(wd_r[7:0]),
		.rd_addr(mode),
		.rd_data(tbl_rd)
	);

	// synchronizer: first stage feeds only the second
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= raw_result;
			sync2_r <= sync1_r;
		end
	end
	// polarity applied after synchronizing; off comparators read as their invert bit, except in mode 111 where both result bits read 0
	assign res_now.second = (sync2_r.second & pw_r.second) ^ ctrl_r[DCC_SECOND_INVERT_BIT];
	assign res_now.first = (sync2_r.first & pw_r.first) ^ ctrl_r[DCC_FIRST_INVERT_BIT];

	// write channel: address and data taken in either order
	assign do_write = aw_got_r && w_got_r && wst_r == DCC_IDLE;
	assign tbl_wr = do_write && awa_r >= DCC_TBL_OFF && awa_r < DCC_TBL_OFF + 8'(4 * TBL_DEPTH) && s_axi_wstrb[0];
	assign ctrl_touch = (do_write && awa_r == DCC_CTRL_OFF)
		|| (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:0] == DCC_CTRL_OFF);

	always_comb begin
		aw_got_nxt = aw_got_r;
		w_got_nxt = w_got_r;
		awa_nxt = awa_r;
		wd_nxt = wd_r;
		wst_nxt = wst_r;
		bresp_nxt = bresp_r;
		ctrl_nxt = ctrl_r;
		flag_nxt = flag_r;
		dir_nxt = dir_r;
		analog_nxt = analog_r;
		latch_nxt = latch_r;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_got_nxt = 1'b1;
			awa_nxt = s_axi_awaddr[7:0];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_got_nxt = 1'b1;
			wd_nxt = s_axi_wdata;
		end
		case (wst_r)
			DCC_IDLE: begin
				if (do_write) begin
					aw_got_nxt = 1'b0;
					w_got_nxt = 1'b0;
					wst_nxt = DCC_RESP;
					bresp_nxt = DCC_RESP_OKAY;
					if (awa_r == DCC_CTRL_OFF) begin
						// result bits are not writable
						ctrl_nxt = (ctrl_r & ~DCC_CTRL_WMASK) | (wd_r[7:0] & DCC_CTRL_WMASK);
					end else if (awa_r == DCC_FLAG_OFF) begin
						flag_nxt = wd_r[7:0] & DCC_FLAG_WMASK;
					end else if (awa_r == DCC_CFG_OFF) begin
						dir_nxt = wd_r[7:0];
					end else if (awa_r == DCC_PORT_OFF) begin
						analog_nxt = wd_r[7:0];
					end else if (!(awa_r >= DCC_TBL_OFF && awa_r < DCC_TBL_OFF + 8'(4 * TBL_DEPTH))) begin
						bresp_nxt = DCC_RESP_SLVERR;
					end
				end
			end
			DCC_RESP: begin
				if (s_axi_bready) begin
					wst_nxt = DCC_IDLE;
				end
			end
			default: wst_nxt = DCC_IDLE;
		endcase
		if (ctrl_touch) begin
			latch_nxt = res_now;
		end
		// mismatch sets the flag, winning over a same-cycle software clear
		if (res_now != latch_r) begin
			flag_nxt[DCC_FLAG_BIT] = 1'b1;
		end
		if (mode == DCC_MODE_OFF) begin
			ctrl_nxt[DCC_SECOND_RESULT_BIT] = 1'b0;
			ctrl_nxt[DCC_FIRST_RESULT_BIT] = 1'b0;
		end else begin
			ctrl_nxt[DCC_SECOND_RESULT_BIT] = res_now.second;
			ctrl_nxt[DCC_FIRST_RESULT_BIT] = res_now.first;
		end
	end

	// mode decode; mode 000 is the reset mode with both powered down
	always_comb begin
		cur = dcc_mode_type'(tbl_rd);
		iref_nxt = 1'b0;
		if (mode == 3'h0 || mode == DCC_MODE_OFF) begin
			cur = '0;
			cur.first_neg_sel = 2'h0;
		end else if (mode == DCC_MODE_INTREF) begin
			iref_nxt = 1'b1;
			cur.first_on = 1'b1;
			cur.second_on = 1'b1;
			cur.first_pin_out = 1'b0;
			cur.second_pin_out = 1'b0;
			// 0 = RF6/AN11,RF4/AN9 ; 1 = RF5/AN10,RF3/AN8
			cur.first_neg_sel = {1'b0, ctrl_r[DCC_INPUT_SWITCH_BIT]};
			cur.second_neg_sel = {1'b0, ctrl_r[DCC_INPUT_SWITCH_BIT]};
		end
		pw_nxt.first = cur.first_on;
		pw_nxt.second = cur.second_on;
		n1_nxt = cur.first_neg_sel;
		n2_nxt = cur.second_neg_sel;
		// direction bit low selects output drive
		pe_nxt.first = cur.first_pin_out && !dir_r[DCC_PIN_FIRST_OUT];
		pe_nxt.second = cur.second_pin_out && !dir_r[DCC_PIN_SECOND_OUT];
		irq_nxt = flag_r[DCC_FLAG_BIT] && flag_r[DCC_ENABLE_BIT] && flag_r[DCC_PERIPH_EN_BIT]
			&& flag_r[DCC_GLOBAL_EN_BIT];
		// sleep does not stop the comparators nor disturb control state
		wake_nxt = flag_r[DCC_SLEEP_BIT] && flag_r[DCC_FLAG_BIT] && flag_r[DCC_ENABLE_BIT];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= DCC_CTRL_RESET;
			flag_r <= DCC_FLAG_RESET;
			dir_r <= DCC_DIR_RESET;
			analog_r <= 8'hFF;
			latch_r <= '0;
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			awa_r <= 8'h00;
			wd_r <= 32'h0000_0000;
			wst_r <= DCC_IDLE;
			bresp_r <= DCC_RESP_OKAY;
			pw_r <= '0;
			pe_r <= '0;
			iref_r <= 1'b0;
			n1_r <= 2'h0;
			n2_r <= 2'h0;
			irq_r <= 1'b0;
			wake_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			flag_r <= flag_nxt;
			dir_r <= dir_nxt;
			analog_r <= analog_nxt;
			latch_r <= latch_nxt;
			aw_got_r <= aw_got_nxt;
			w_got_r <= w_got_nxt;
			awa_r <= awa_nxt;
			wd_r <= wd_nxt;
			wst_r <= wst_nxt;
			bresp_r <= bresp_nxt;
			pw_r <= pw_nxt;
			pe_r <= pe_nxt;
			iref_r <= iref_nxt;
			n1_r <= n1_nxt;
			n2_r <= n2_nxt;
			irq_r <= irq_nxt;
			wake_r <= wake_nxt;
		end
	end

	// read channel: one read at a time, answer one cycle after address
	always_comb begin
		rst_nxt = rst_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		case (rst_r)
			DCC_IDLE: begin
				if (s_axi_arvalid) begin
					rst_nxt = DCC_RESP;
					rresp_nxt = DCC_RESP_OKAY;
					rdata_nxt = 32'h0000_0000;
					if (s_axi_araddr[7:0] == DCC_CTRL_OFF) begin
						rdata_nxt[7:0] = ctrl_r;
					end else if (s_axi_araddr[7:0] == DCC_FLAG_OFF) begin
						rdata_nxt[7:0] = flag_r;
					end else if (s_axi_araddr[7:0] == DCC_CFG_OFF) begin
						rdata_nxt[7:0] = dir_r;
					end else if (s_axi_araddr[7:0] == DCC_PORT_OFF) begin
						rdata_nxt[7:0] = port_f_pins & ~analog_r;
					end else begin
						rresp_nxt = DCC_RESP_SLVERR;
					end
				end
			end
			DCC_RESP: begin
				if (s_axi_rready) begin
					rst_nxt = DCC_IDLE;
				end
			end
			default: rst_nxt = DCC_IDLE;
		endcase
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rst_r <= DCC_IDLE;
			rdata_r <= 32'h0000_0000;
			rresp_r <= DCC_RESP_OKAY;
		end else begin
			rst_r <= rst_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end

	assign s_axi_awready = !aw_got_r && wst_r == DCC_IDLE;
	assign s_axi_wready = !w_got_r && wst_r == DCC_IDLE;
	assign s_axi_bvalid = wst_r == DCC_RESP;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = rst_r == DCC_IDLE;
	assign s_axi_rvalid = rst_r == DCC_RESP;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign power_on = pw_r;
	assign use_internal_ref = iref_r;
	assign first_neg_sel = n1_r;
	assign second_neg_sel = n2_r;
	assign port_f_direction = dir_r;
	// analog mux takes raw comparator outputs to the pins, bypassing sync
	assign pin_out_en = {pe_r.second, pe_r.first};
	assign pin_out_sel = {pe_r.second, pe_r.first};
	assign irq_req = irq_r;
	assign wake_req = wake_r;
	// left to software: mask enable before changing mode
endmodule // dcc_top
`default_nettype wire

/* File: test/dcc_analog_model.sv */
// dcc_analog_model: comparator pair and port pins beside the block.
// assumes the bench sets the voltages; results are unsynchronized.
`timescale 1ns/1ps
`default_nettype none
module dcc_analog_model #(
	parameter int DLY = 3
) (
	input wire dcc_pkg::dcc_pair_type power_on,
	input wire logic use_internal_ref,
	input wire logic [1:0] first_neg_sel,
	input wire logic [1:0] second_neg_sel,
	input wire logic [7:0] vref,
	input wire logic [7:0] vsw,
	input wire logic [7:0] vdef,
	input wire logic [7:0] pin_lv,
	output var dcc_pkg::dcc_pair_type raw_result,
	output logic [7:0] port_f_pins
);
	logic [7:0] pos;
	// outside mode 110 both sides sit on plain pins
	assign pos = use_internal_ref ? vref : vdef;
	// a powered-down comparator rests low
	assign #(DLY) raw_result.first = power_on.first && pos > (first_neg_sel[0] ? vsw : vdef);
	assign #(DLY) raw_result.second = power_on.second && pos > (second_neg_sel[0] ? vsw : vdef);
	assign port_f_pins = pin_lv;
endmodule // dcc_analog_model
`default_nettype wire

/* File: test/dcc_checker.sv */
// dcc_checker: bus and reset properties at the top ports.
// assumes one clock aclk and sync active-low aresetn.
`timescale 1ns/1ps
`default_nettype none
module dcc_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire dcc_pkg::dcc_pair_type power_on,
	input wire logic use_internal_ref,
	input wire logic [7:0] port_f_direction
);
	import dcc_pkg::*;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_reset_state;
		$rose(aresetn) |-> power_on == 2'b00 && !use_internal_ref && port_f_direction == 8'hFF;
	endproperty
	a_reset_state: assert property (p_reset_state)
		else $error("state after reset wrong");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	a_b_hold: assert property (p_b_hold)
		else $error("write response dropped");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rresp);
	endproperty
	a_r_hold: assert property (p_r_hold)
		else $error("read response dropped");
	property p_b_lat;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
	endproperty
	a_b_lat: assert property (p_b_lat)
		else $error("write response late");
	property p_r_lat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_r_lat: assert property (p_r_lat)
		else $error("read response late");
	property p_w_refuse;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_w_refuse: assert property (p_w_refuse)
		else $error("write taken while answering");
	property p_r_refuse;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_r_refuse: assert property (p_r_refuse)
		else $error("read taken while answering");
	property p_unmapped;
		s_axi_arvalid && s_axi_arready && s_axi_araddr[7:0] > 8'h2C |=> s_axi_rresp == DCC_RESP_SLVERR;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not refused");
endmodule // dcc_checker
`default_nettype wire

/* File: test/test_dual_comparator_control.sv */
// test_dual_comparator_control: self-checking bench for dcc_top.
// assumes dcc_analog_model on the far side, AXI4-Lite master here.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
	$display("mismatch at %0t: got %h want %h", $time, g, e); end end
module test_dual_comparator_control;
	import dcc_pkg::*;
	logic aclk = 0, aresetn = 0;
	logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, first_neg_sel, second_neg_sel, pin_out_en, pin_out_sel;
	logic [7:0] port_f_pins, port_f_direction;
	logic use_internal_ref, irq_req, wake_req;
	dcc_pair_type raw_result, power_on;
	logic [7:0] vref = 8'hC8, vsw = 8'hFA, vdef = 8'h64, pin_lv = 8'hAA;
	int failures = 0, check_count = 0;
	always #5 aclk = ~aclk;
	dcc_top u_dut (.*);
	dcc_analog_model u_ana (.*);
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic hung();
		failures++;
		$display("mismatch at %0t: no answer", $time);
		close_out();
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= {24'h00_0000, a};
		s_axi_wdata <= {24'h00_0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		if (n == 64) hung();
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		s_axi_araddr <= {24'h00_0000, a};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		if (n == 64) hung();
		d = s_axi_rdata[7:0];
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// write, then let the synchronizer and output flops settle
	task automatic w(input logic [7:0] a, input logic [7:0] d);
		logic [1:0] r;
		wr(a, d, r);
		`CHK(r, DCC_RESP_OKAY)
		repeat (6) @(posedge aclk);
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic [1:0] r;
		rd(a, d, r);
		`CHK(d, e)
	endtask
	task automatic t_reset();
		`CHK(power_on, 2'b00)
		`CHK(port_f_direction, 8'hFF)
		rc(DCC_CTRL_OFF, 8'h00);
		rc(DCC_FLAG_OFF, 8'h00);
		rc(DCC_CFG_OFF, 8'hFF);
		rc(DCC_PORT_OFF, 8'h00);
	endtask
	task automatic t_modes();
		w(DCC_CTRL_OFF, 8'h07);
		`CHK(power_on, 2'b00)
		w(DCC_CTRL_OFF, 8'h06);
		`CHK(use_internal_ref, 1'b1)
		`CHK({first_neg_sel, second_neg_sel}, 4'h0)
		rc(DCC_CTRL_OFF, 8'hC6);
		w(DCC_CTRL_OFF, 8'h0E);
		`CHK({first_neg_sel, second_neg_sel}, 4'h5)
		rc(DCC_CTRL_OFF, 8'h0E);
		w(DCC_CTRL_OFF, 8'hF6);
		rc(DCC_CTRL_OFF, 8'h36);
	endtask
	task automatic t_flag();
		w(DCC_FLAG_OFF, 8'h00);
		rc(DCC_FLAG_OFF, 8'h00);
		vref <= 8'h00;
		repeat (6) @(posedge aclk);
		w(DCC_FLAG_OFF, 8'h00);
		rc(DCC_FLAG_OFF, 8'h01);
		rc(DCC_CTRL_OFF, 8'hF6);
		w(DCC_FLAG_OFF, 8'h00);
		rc(DCC_FLAG_OFF, 8'h00);
		w(DCC_FLAG_OFF, 8'h01);
		rc(DCC_FLAG_OFF, 8'h01);
		w(DCC_FLAG_OFF, 8'h0F);
		`CHK(irq_req, 1'b1)
		w(DCC_FLAG_OFF, 8'h0B);
		`CHK(irq_req, 1'b0)
		rc(DCC_FLAG_OFF, 8'h0B);
		w(DCC_FLAG_OFF, 8'h00);
	endtask
	task automatic t_sleep();
		w(DCC_FLAG_OFF, 8'h12);
		vref <= 8'hC8;
		repeat (6) @(posedge aclk);
		`CHK(wake_req, 1'b1)
		rc(DCC_CTRL_OFF, 8'h36);
		w(DCC_FLAG_OFF, 8'h00);
	endtask
	task automatic t_pins();
		logic [7:0] d;
		logic [1:0] r;
		w(DCC_TBL_OFF + 8'h04, 8'hC3);
		w(DCC_CFG_OFF, 8'hF9);
		w(DCC_CTRL_OFF, 8'h01);
		`CHK(pin_out_en, 2'b11)
		`CHK(pin_out_sel, 2'b11)
		`CHK(power_on, 2'b11)
		w(DCC_CFG_OFF, 8'hFF);
		`CHK(pin_out_en, 2'b00)
		`CHK(pin_out_sel, 2'b00)
		w(DCC_PORT_OFF, 8'hF0);
		rc(DCC_PORT_OFF, 8'h0A);
		wr(8'h40, 8'h00, r);
		`CHK(r, DCC_RESP_SLVERR)
		rd(8'h40, d, r);
		`CHK(r, DCC_RESP_SLVERR)
	endtask
	task automatic t_rerun();
		w(DCC_CTRL_OFF, 8'h06);
		`CHK(power_on, 2'b11)
		w(DCC_CTRL_OFF, 8'h07);
		`CHK(power_on, 2'b00)
		rc(DCC_CTRL_OFF, 8'h07);
		w(DCC_CTRL_OFF, 8'h06);
		// mid-run reset must undo everything configured above
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
	endtask
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_modes();
		t_flag();
		t_sleep();
		t_pins();
		t_rerun();
		close_out();
	end
endmodule // test_dual_comparator_control
bind dcc_top dcc_checker u_chk (.*);
`default_nettype wire
